// [verilog/fps_map.vh]
/*
  Constants for the fan PWM fault supervisor: duty scale, window lengths,
  pulse count thresholds and reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef FPS_MAP_VH
`define FPS_MAP_VH

// ----------------------------------------------------------------------
// duty scale and ramp
// ----------------------------------------------------------------------
`define FPS_DUTY_W 8
`define FPS_DUTY_FULL 8'hFF
`define FPS_PRESCALE_DEF 16'h0010

// ----------------------------------------------------------------------
// supervision windows, counted in pwm periods, and the release pulse count
// ----------------------------------------------------------------------
`define FPS_STARTUP_PERIODS 6'h20
`define FPS_MISSING_PULSE_WINDOW 6'h20
`define FPS_RELEASE_PULSES 6'h10

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FPS_RST_DRIVE 1'b0
`define FPS_RST_ALARM_OE 1'b0

`endif

// [verilog/fps_ramp.v]
/*
  Ramp oscillator: a sawtooth counter across the duty scale with a prescaler,
  marking each completed pwm period with a one-cycle pulse.
  Assumes one clock and a synchronous active-high reset.
*/
`include "fps_map.vh"
`default_nettype none

module fps_ramp #(
  parameter DUTY_W = `FPS_DUTY_W,
  parameter PRE_W = 16,
  parameter [PRE_W-1:0] PRESCALE = `FPS_PRESCALE_DEF
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire run,
  output reg [DUTY_W-1:0] ramp_reg,
  output reg period_end_reg
);

  reg [PRE_W-1:0] pre_reg;

  // ----------------------------------------------------------------------
  // sawtooth
  // ----------------------------------------------------------------------
  // ramp spans 0..full-1 so a request of full scale is always above it
  always @(posedge clk_sys) begin
    if (sys_rst || !run) begin
      pre_reg <= {PRE_W{1'b0}};
      ramp_reg <= {DUTY_W{1'b0}};
      period_end_reg <= 1'b0;
    end else begin
      period_end_reg <= 1'b0;
      if (pre_reg == PRESCALE - 1'b1) begin
        pre_reg <= {PRE_W{1'b0}};
        if (ramp_reg == {{(DUTY_W-1){1'b1}}, 1'b0}) begin
          ramp_reg <= {DUTY_W{1'b0}};
          period_end_reg <= 1'b1;
        end else begin
          ramp_reg <= ramp_reg + 1'b1;
        end
      end else begin
        pre_reg <= pre_reg + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [verilog/fps_top.v]
/*
  Fan PWM fault supervisor top: duty selection, start-up sequence, missing
  pulse supervision, alarm release and the drive and alarm pins.
  Assumes synchronous sampled inputs: duty requests already digitised from
  the analog levels, shutdown and over-temperature flags from comparators,
  and a tach level already synchronised to clk_sys.
*/
// Notes on behaviour
// - temperature request maps linearly onto duty
// - minimum request sets duty floor
// - shutdown when minimum level at threshold
// - alarm released during shutdown
// - missing tach pulses mean fan fault
// - alarm is open drain, low on fault
// - release after 16 pulses in 32 periods
// - optional overtemp flag also asserts alarm
// - drive fully on during fan fault
// - drive high turns fan on
// - fault not latched, recovers to pwm
// - fixed period, only on-time varies
// - start-up drives high 32 periods
// - retry start-up once, then alarm
// - larger of two requests sets duty
// - drive held low in shutdown
`include "fps_map.vh"
`default_nettype none

module fps_top #(
  parameter DUTY_W = `FPS_DUTY_W,
  parameter PRE_W = 16,
  parameter [PRE_W-1:0] PRESCALE = `FPS_PRESCALE_DEF,
  parameter HAS_OVERTEMP = 1
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire [DUTY_W-1:0] temp_duty,
  input wire [DUTY_W-1:0] min_duty,
  input wire shutdown_threshold,
  input wire overtemp_threshold,
  input wire tach_in,
  output reg fan_drive_reg,
  output reg alarm_out_reg,
  output reg alarm_oe_reg
);

  localparam [3:0] ST_SHUT = 4'h1;
  localparam [3:0] ST_START = 4'h2;
  localparam [3:0] ST_RUN = 4'h4;
  localparam [3:0] ST_FAULT = 4'h8;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg retry_reg;
  reg retry_next;
  reg alarm_fan_reg;
  reg alarm_fan_next;
  reg tach_d_reg;
  reg [5:0] per_cnt_reg;
  reg [5:0] pulse_cnt_reg;
  reg [DUTY_W-1:0] duty_reg;
  wire [DUTY_W-1:0] ramp;
  wire period_end;
  wire tach_edge;
  wire win_end;
  wire [5:0] pulses_now;

  function [DUTY_W-1:0] duty_max;
    input [DUTY_W-1:0] a;
    input [DUTY_W-1:0] b;
    begin
      duty_max = (a > b) ? a : b;
    end
  endfunction

  // ----------------------------------------------------------------------
  // ramp oscillator
  // ----------------------------------------------------------------------
  fps_ramp #(
    .DUTY_W(DUTY_W),
    .PRE_W(PRE_W),
    .PRESCALE(PRESCALE)
  ) u_ramp (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .run(state_reg != ST_SHUT),
    .ramp_reg(ramp),
    .period_end_reg(period_end)
  );

  // ----------------------------------------------------------------------
  // tach edge and window counting
  // ----------------------------------------------------------------------
  assign tach_edge = tach_in & ~tach_d_reg;
  assign win_end = period_end && (per_cnt_reg == `FPS_MISSING_PULSE_WINDOW - 6'h01);
  // saturate so a fast fan cannot wrap the count back to zero
  assign pulses_now = (tach_edge && pulse_cnt_reg != 6'h3F) ?
    pulse_cnt_reg + 6'h01 : pulse_cnt_reg;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      tach_d_reg <= 1'b0;
      per_cnt_reg <= 6'h00;
      pulse_cnt_reg <= 6'h00;
    end else begin
      tach_d_reg <= tach_in;
      if (state_next != state_reg || state_reg == ST_SHUT) begin
        per_cnt_reg <= 6'h00;
        pulse_cnt_reg <= 6'h00;
      end else if (win_end) begin
        per_cnt_reg <= 6'h00;
        pulse_cnt_reg <= 6'h00;
      end else begin
        if (period_end) begin
          per_cnt_reg <= per_cnt_reg + 6'h01;
        end
        pulse_cnt_reg <= pulses_now;
      end
    end
  end

  // ----------------------------------------------------------------------
  // supervision state machine
  // ----------------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    retry_next = retry_reg;
    alarm_fan_next = alarm_fan_reg;
    case (state_reg)
      ST_SHUT: begin
        alarm_fan_next = 1'b0;
        retry_next = 1'b0;
        if (!shutdown_threshold) begin
          state_next = ST_START;
        end
      end
      ST_START: begin
        if (win_end) begin
          if (pulses_now != 6'h00) begin
            state_next = ST_RUN;
          end else if (!retry_reg) begin
            retry_next = 1'b1;
          end else begin
            state_next = ST_FAULT;
            alarm_fan_next = 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (win_end && pulses_now == 6'h00) begin
          state_next = ST_FAULT;
          alarm_fan_next = 1'b1;
        end
      end
      ST_FAULT: begin
        if (win_end && pulses_now >= `FPS_RELEASE_PULSES) begin
          state_next = ST_RUN;
          alarm_fan_next = 1'b0;
        end
      end
      default: begin
        state_next = ST_SHUT;
      end
    endcase
    if (shutdown_threshold) begin
      state_next = ST_SHUT;
      alarm_fan_next = 1'b0;
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= ST_SHUT;
      retry_reg <= 1'b0;
      alarm_fan_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      retry_reg <= retry_next;
      alarm_fan_reg <= alarm_fan_next;
    end
  end

  // ----------------------------------------------------------------------
  // duty and outputs
  // ----------------------------------------------------------------------
  // duty is latched at the period boundary so the period stays fixed and
  // a request change mid-period cannot produce a runt pulse
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      duty_reg <= {DUTY_W{1'b0}};
    end else if (period_end || state_reg != ST_RUN) begin
      duty_reg <= duty_max(temp_duty, min_duty);
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      fan_drive_reg <= `FPS_RST_DRIVE;
      alarm_out_reg <= 1'b0;
      alarm_oe_reg <= `FPS_RST_ALARM_OE;
    end else begin
      alarm_out_reg <= 1'b0;
      case (state_next)
        ST_SHUT: begin
          fan_drive_reg <= 1'b0;
          alarm_oe_reg <= 1'b0;
        end
        ST_START, ST_FAULT: begin
          fan_drive_reg <= 1'b1;
          alarm_oe_reg <= alarm_fan_next ||
            (HAS_OVERTEMP != 0 && overtemp_threshold);
        end
        default: begin
          fan_drive_reg <= (duty_reg > ramp);
          alarm_oe_reg <= alarm_fan_next ||
            (HAS_OVERTEMP != 0 && overtemp_threshold);
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// [sim/fps_properties.sv]
/* Pin checker for fps_top.
   Assumes a pwm period of 255 * PRESCALE clocks. */
`default_nettype none
module fps_chk #(parameter int PRESCALE = 16) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic shutdown_threshold,
  input wire logic overtemp_threshold,
  input wire logic tach_in,
  input wire logic fan_drive_reg,
  input wire logic alarm_out_reg,
  input wire logic alarm_oe_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PER = 255 * PRESCALE;
  logic [19:0] rel_cnt;
  logic [19:0] idle_cnt;
  logic tach_q;
  // both counts restart on shutdown so each start-up is judged alone
  always @(posedge clk_sys) begin
    tach_q <= tach_in;
    if (sys_rst || shutdown_threshold) rel_cnt <= '0;
    else if (!(&rel_cnt)) rel_cnt <= rel_cnt + 1'b1;
    if (sys_rst || shutdown_threshold || (tach_in && !tach_q)) idle_cnt <= '0;
    else if (!(&idle_cnt)) idle_cnt <= idle_cnt + 1'b1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_hot;
    (overtemp_threshold && !shutdown_threshold) [*3];
  endsequence
  AST_SHDN_DRV: assert property (shutdown_threshold |=> !fan_drive_reg)
    else $error("drive on in shutdown");
  AST_SHDN_ALM: assert property (shutdown_threshold |=> !alarm_oe_reg)
    else $error("alarm in shutdown");
  AST_OD: assert property (!alarm_out_reg)
    else $error("alarm pin driven high");
  AST_FLT_DRV: assert property (alarm_oe_reg && !overtemp_threshold
    && !$past(overtemp_threshold) |-> fan_drive_reg) else $error("fault drive off");
  AST_HOT: assert property (s_hot |-> alarm_oe_reg)
    else $error("overtemp without alarm");
  AST_START: assert property (rel_cnt != 0 && rel_cnt < 31 * PER |-> fan_drive_reg)
    else $error("start-up drive low");
  AST_RETRY: assert property ($rose(alarm_oe_reg) && !$past(overtemp_threshold)
    |-> rel_cnt >= 62 * PER) else $error("fault before retry");
  AST_MISS: assert property (idle_cnt >= 96 * PER |-> fan_drive_reg && alarm_oe_reg)
    else $error("missing pulses ignored");
endmodule

bind fps_top fps_chk #(.PRESCALE(PRESCALE)) i_chk (
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .shutdown_threshold(shutdown_threshold),
  .overtemp_threshold(overtemp_threshold),
  .tach_in(tach_in),
  .fan_drive_reg(fan_drive_reg),
  .alarm_out_reg(alarm_out_reg),
  .alarm_oe_reg(alarm_oe_reg)
);
`default_nettype wire

// [sim/fps_fan.sv]
/* Fan behind the drive transistor with its sense resistor.
   Assumes spin_en from the bench stands for a free or a stalled rotor. */
`default_nettype none
module fps_fan (
  input wire logic clk_sys,
  input wire logic fan_drive,
  input wire logic spin_en,
  output logic tach
);
  timeunit 1ns;
  timeprecision 1ns;
  logic spin_reg = 1'b0;
  logic [6:0] cnt_reg = '0;
  // inertia keeps the rotor turning between drive pulses
  always @(posedge clk_sys) begin
    spin_reg <= spin_en && (spin_reg || fan_drive);
    cnt_reg <= cnt_reg + 1'b1;
  end
  // a stalled rotor leaves the sense node at ground
  assign tach = spin_reg && cnt_reg[6];
endmodule
`default_nettype wire

// [sim/fan_pwm_fault_supervisor_tb_top.sv]
/* Bench for fps_top: duty table, stall and recovery, overtemp, shutdown, retry.
   Assumes PRESCALE 1, a period of 255 clocks. */
`default_nettype none
module fan_pwm_fault_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PER = 255;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] temp_duty = 8'h00;
  logic [7:0] min_duty = 8'h00;
  logic sd = 1'b0;
  logic ot = 1'b0;
  logic spin_en = 1'b1;
  logic tach;
  wire drv;
  wire a_out;
  wire oe;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [7:0] t_tab [4] = '{8'h40, 8'h10, 8'hFF, 8'h00};
  logic [7:0] m_tab [4] = '{8'h10, 8'h80, 8'h00, 8'h01};
  logic [8:0] e_tab [4] = '{9'h040, 9'h080, 9'h0FF, 9'h001};
  always #4 clk_sys = ~clk_sys;
  fps_top #(.PRESCALE(16'h0001)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .temp_duty(temp_duty), .min_duty(min_duty), .shutdown_threshold(sd),
    .overtemp_threshold(ot), .tach_in(tach), .fan_drive_reg(drv),
    .alarm_out_reg(a_out), .alarm_oe_reg(oe));
  fps_fan i_fan (.clk_sys(clk_sys), .fan_drive(drv), .spin_en(spin_en), .tach(tach));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic on_cnt(output logic [8:0] n);
    n = '0;
    repeat (PER) begin
      @(negedge clk_sys);
      n = n + {8'h00, drv};
    end
  endtask
  task automatic wait_oe(input logic v);
    int i;
    i = 0;
    while (oe !== v && i < 100 * PER) begin
      @(negedge clk_sys);
      i++;
    end
  endtask
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ceiling sits above the worst case of every fault wait together
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 100000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    logic [8:0] n;
    repeat (8) @(negedge clk_sys);
    chk({6'h00, drv, oe, a_out}, 9'h000);
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    // the drive rises on the first edge that sees reset low
    @(posedge clk_sys);
    on_cnt(n);
    chk(n, 9'h0FF);
    repeat (33 * PER) @(posedge clk_sys);
    for (int r = 0; r < 4; r++) begin
      temp_duty <= t_tab[r];
      min_duty <= m_tab[r];
      repeat (2 * PER) @(posedge clk_sys);
      on_cnt(n);
      chk(n, e_tab[r]);
      chk({8'h00, oe}, 9'h000);
      @(posedge clk_sys);
    end
    $display("test duty done");
    temp_duty <= 8'h40;
    min_duty <= 8'h00;
    spin_en <= 1'b0;
    wait_oe(1'b1);
    chk({8'h00, oe}, 9'h001);
    on_cnt(n);
    chk(n, 9'h0FF);
    @(posedge clk_sys);
    spin_en <= 1'b1;
    repeat (4 * PER) @(negedge clk_sys);
    chk({8'h00, oe}, 9'h001);
    wait_oe(1'b0);
    chk({8'h00, oe}, 9'h000);
    repeat (2 * PER) @(posedge clk_sys);
    on_cnt(n);
    chk(n, 9'h040);
    $display("test stall done");
    @(posedge clk_sys);
    ot <= 1'b1;
    repeat (4) @(negedge clk_sys);
    chk({8'h00, oe}, 9'h001);
    @(posedge clk_sys);
    sd <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({7'h00, drv, oe}, 9'h000);
    @(posedge clk_sys);
    ot <= 1'b0;
    spin_en <= 1'b0;
    sd <= 1'b0;
    @(posedge clk_sys);
    on_cnt(n);
    chk(n, 9'h0FF);
    repeat (40 * PER) @(negedge clk_sys);
    chk({8'h00, oe}, 9'h000);
    // retry window closes 64 periods after release; probe one period either side
    repeat (22 * PER) @(negedge clk_sys);
    chk({8'h00, oe}, 9'h000);
    repeat (2 * PER) @(negedge clk_sys);
    chk({7'h00, drv, oe}, 9'h003);
    $display("test shutdown done");
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({6'h00, drv, oe, a_out}, 9'h000);
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({7'h00, drv, oe}, 9'h002);
    $display("test reset done");
    finish_test();
  end
endmodule
`default_nettype wire
